/* File: design/crf_cpu_register_file.sv */
`timescale 1ns/1ns
`include "crf_defines.svh"

module crf_cpu_register_file
	import crf_pkg::*;
#(
	parameter int AV_ADDR_W = 8
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// core write port
	input  wire logic                 coreWrEn,
	input  wire crf_sel_t             coreWrSel,
	input  wire crf_size_e            coreWrSize,
	input  wire crf_word_t            coreWrData,
	// multiply unit result
	input  wire logic                 macWrEn,
	input  wire crf_word_t            macHighIn,
	input  wire crf_word_t            macLowIn,
	// core read ports, one cycle latency
	input  wire crf_sel_t             rdSelA,
	input  wire crf_sel_t             rdSelB,
	output crf_word_t                 rdDataA,
	output crf_word_t                 rdDataB,
	// dedicated register views
	output crf_word_t                 indexRegister,
	output crf_word_t                 stackPointer,
	output crf_word_t                 processorState,
	output logic [3:0]                interruptMaskBits,
	output crf_word_t                 globalBase,
	output crf_word_t                 vectorBase,
	output crf_word_t                 mulAccHigh,
	output crf_word_t                 mulAccLow,
	output crf_word_t                 returnAddress,
	output crf_word_t                 programCounter,
	output logic                      coreReady,
	// reset vector fetch
	output logic                      vecReq,
	output crf_word_t                 vecAddr,
	input  wire crf_word_t            vecData,
	input  wire logic                 vecValid,
	// avalon-mm slave
	input  wire logic [AV_ADDR_W-1:0] avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire crf_word_t            avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output crf_word_t                 avs_readdata,
	output logic                      avs_waitrequest
);

	// widen a byte or word operand to a longword by its top bit
	function automatic crf_word_t crf_extend(crf_word_t d, crf_size_e s);
		case (s)
			CRF_SZ_BYTE: crf_extend = {{24{d[7]}}, d[7:0]};
			CRF_SZ_WORD: crf_extend = {{16{d[15]}}, d[15:0]};
			default:     crf_extend = d;
		endcase
	endfunction : crf_extend

	// merge enabled byte lanes of new data over the old value
	function automatic crf_word_t crf_merge(crf_word_t old, crf_word_t d, logic [3:0] be);
		crf_word_t r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		crf_merge = r;
	endfunction : crf_merge

	// register storage
	crf_word_t gpr [16];
	crf_word_t sr;
	crf_word_t global_base;
	crf_word_t vector_base;
	crf_word_t mul_acc_high;
	crf_word_t mul_acc_low;
	crf_word_t pr;
	crf_word_t pc;
	crf_boot_e bootState;

	// flat views: present and next value of every selector
	crf_word_t view     [32];
	crf_word_t nextView [32];

	// bus decode
	crf_sel_t  busSel;
	logic      busHit;
	logic      busCommit;
	logic      wrEn;
	crf_sel_t  wrSel;
	crf_word_t wrVal;

	assign busSel    = avs_address[6:2];
	assign busHit    = (avs_address[AV_ADDR_W-1:7] == '0) && (busSel <= `CRF_SEL_STAT);
	assign busCommit = avs_write && !avs_waitrequest && busHit;

	// dedicated views come straight from storage
	assign indexRegister     = gpr[0];
	assign stackPointer      = gpr[15];
	assign processorState    = sr;
	assign interruptMaskBits = sr[`CRF_SR_IMASK_MSB:`CRF_SR_IMASK_LSB];
	assign globalBase        = global_base;
	assign vectorBase        = vector_base;
	assign mulAccHigh        = mul_acc_high;
	assign mulAccLow         = mul_acc_low;
	assign returnAddress     = pr;
	assign programCounter    = pc;

	// present value of every selector, status word at the top
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			view[i] = '0;
		end
		for (int i = 0; i < 16; i++) begin
			view[i] = gpr[i];
		end
		view[`CRF_SEL_SR]   = sr;
		view[`CRF_SEL_GBR]  = global_base;
		view[`CRF_SEL_VBR]  = vector_base;
		view[`CRF_SEL_MUL_ACC_HIGH] = mul_acc_high;
		view[`CRF_SEL_MUL_ACC_LOW] = mul_acc_low;
		view[`CRF_SEL_PR]   = pr;
		view[`CRF_SEL_PC]   = pc;
		view[`CRF_SEL_STAT] = {31'h0000_0000, bootState == CRF_RUN};
	end

	// single write port: core first, bus only when core is idle
	always_comb begin
		wrEn  = 1'b0;
		wrSel = '0;
		wrVal = '0;
		if (bootState == CRF_RUN && coreWrEn && coreWrSel <= `CRF_SEL_PC) begin
			wrEn  = 1'b1;
			wrSel = coreWrSel;
			wrVal = crf_extend(coreWrData, coreWrSize);
		end else if (busCommit && busSel <= `CRF_SEL_PC) begin
			wrEn  = 1'b1;
			wrSel = busSel;
			wrVal = crf_merge(view[busSel], avs_writedata, avs_byteenable);
		end
	end

	// next value of every selector: boot loads, mac, then the write port
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			nextView[i] = view[i];
		end
		if (bootState == CRF_FETCH_PC && vecValid) begin
			nextView[`CRF_SEL_PC] = vecData;
		end
		if (bootState == CRF_FETCH_SP && vecValid) begin
			nextView[`CRF_SEL_STACK] = vecData;
		end
		if (macWrEn) begin
			nextView[`CRF_SEL_MUL_ACC_HIGH] = macHighIn;
			nextView[`CRF_SEL_MUL_ACC_LOW] = macLowIn;
		end
		if (wrEn) begin
			nextView[wrSel] = wrVal;
		end
		nextView[`CRF_SEL_SR] = nextView[`CRF_SEL_SR] & `CRF_SR_WRITABLE; // reserved bits stay 0
	end

	// registers left undefined by reset: general set, global base, mac, return
	always_ff @(posedge clk) begin
		for (int i = 0; i < 16; i++) begin
			gpr[i] <= nextView[i];
		end
		global_base  <= nextView[`CRF_SEL_GBR];
		mul_acc_high <= nextView[`CRF_SEL_MUL_ACC_HIGH];
		mul_acc_low <= nextView[`CRF_SEL_MUL_ACC_LOW];
		pr   <= nextView[`CRF_SEL_PR];
	end

	// registers with a defined reset value
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sr  <= `CRF_SR_RESET;
			vector_base <= `CRF_VBR_RESET;
			pc  <= `CRF_PC_RESET;
		end else begin
			sr  <= nextView[`CRF_SEL_SR];
			vector_base <= nextView[`CRF_SEL_VBR];
			pc  <= nextView[`CRF_SEL_PC];
		end
	end

	// reset vector fetch: program counter first, then stack pointer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bootState <= CRF_FETCH_PC;
			vecReq    <= 1'b1;
			vecAddr   <= `CRF_VBR_RESET + `CRF_VEC_PC_OFF;
			coreReady <= 1'b0;
		end else begin
			case (bootState)
				CRF_FETCH_PC: begin
					if (vecValid) begin
						bootState <= CRF_FETCH_SP;
						vecAddr   <= vector_base + `CRF_VEC_SP_OFF;
					end
				end
				CRF_FETCH_SP: begin
					if (vecValid) begin
						bootState <= CRF_RUN;
						vecReq    <= 1'b0;
						coreReady <= 1'b1;
					end
				end
				CRF_RUN: begin
					vecReq <= 1'b0;
				end
				default: begin
					bootState <= CRF_FETCH_PC;
					vecReq    <= 1'b1;
					vecAddr   <= vector_base + `CRF_VEC_PC_OFF;
					coreReady <= 1'b0;
				end
			endcase
		end
	end

	// core read ports with forwarding of the value being written
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdDataA <= '0;
			rdDataB <= '0;
		end else begin
			rdDataA <= nextView[rdSelA];
			rdDataB <= nextView[rdSelB];
		end
	end

	// bus slave: held off until boot ends, then one wait cycle and a single-cycle answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= '0;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;                                     // answer taken, release
		end else if ((avs_read || avs_write) && bootState == CRF_RUN) begin
			avs_waitrequest <= 1'b0;
			if (avs_read && busHit) begin
				avs_readdata <= view[busSel];
			end else begin
				avs_readdata <= '0;                                      // unmapped or write
			end
		end
	end

endmodule : crf_cpu_register_file

/* File: design/crf_defines.svh */
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH

// register selector codes, shared by the core ports and the bus map
`define CRF_SEL_INDEX   5'h00
`define CRF_SEL_STACK   5'h0F
`define CRF_SEL_SR      5'h10
`define CRF_SEL_GBR     5'h11
`define CRF_SEL_VBR     5'h12
`define CRF_SEL_MUL_ACC_HIGH    5'h13
`define CRF_SEL_MUL_ACC_LOW    5'h14
`define CRF_SEL_PR      5'h15
`define CRF_SEL_PC      5'h16
`define CRF_SEL_STAT    5'h17

// bus byte offsets (word aligned, byte address = selector * 4)
`define CRF_OFF_GPR0    8'h00
`define CRF_OFF_SR      8'h40
`define CRF_OFF_GBR     8'h44
`define CRF_OFF_VBR     8'h48
`define CRF_OFF_MUL_ACC_HIGH    8'h4C
`define CRF_OFF_MUL_ACC_LOW    8'h50
`define CRF_OFF_PR      8'h54
`define CRF_OFF_PC      8'h58
`define CRF_OFF_STAT    8'h5C

// processor state layout
`define CRF_SR_IMASK_LSB 4
`define CRF_SR_IMASK_MSB 7
`define CRF_SR_WRITABLE  32'h0000_03F3
`define CRF_SR_RESET     32'h0000_00F0

// reset values and vector table layout
`define CRF_VBR_RESET    32'h0000_0000
`define CRF_PC_RESET     32'h0000_0000
`define CRF_VEC_PC_OFF   32'h0000_0000
`define CRF_VEC_SP_OFF   32'h0000_0004

`endif

/* File: design/crf_pkg.sv */
package crf_pkg;

	// reset-time vector fetch sequence, gray coded
	typedef enum logic [1:0] {
		CRF_FETCH_PC = 2'b00,
		CRF_FETCH_SP = 2'b01,
		CRF_RUN      = 2'b11
	} crf_boot_e;

	// size of the memory operand being written
	typedef enum logic [1:0] {
		CRF_SZ_BYTE = 2'b00,
		CRF_SZ_WORD = 2'b01,
		CRF_SZ_LONG = 2'b10
	} crf_size_e;

	typedef logic [31:0] crf_word_t;
	typedef logic [4:0]  crf_sel_t;

endpackage : crf_pkg

/* File: testbench/crf_cpu_register_file_props.sv */
`timescale 1ns/1ns
`include "crf_defines.svh"

// port checks beside the register file
module crf_cpu_register_file_props
	import crf_pkg::*;
(
	// strobes
	input wire logic      clk, rst_n, coreWrEn, macWrEn, coreReady, vecReq, vecValid,
	input wire logic      avs_read, avs_write, avs_waitrequest,
	// selectors
	input wire crf_sel_t  coreWrSel, rdSelA, rdSelB,
	input wire logic [7:0] avs_address,
	input wire logic [3:0] avs_byteenable,
	input wire crf_size_e coreWrSize,
	input wire logic [3:0] interruptMaskBits,
	// data and views
	input wire crf_word_t coreWrData, macHighIn, rdDataA, indexRegister, stackPointer,
	input wire crf_word_t processorState, vectorBase, mulAccHigh, programCounter,
	input wire crf_word_t vecAddr, vecData, rdDataB, globalBase, mulAccLow, macLowIn,
	input wire crf_word_t returnAddress, avs_writedata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// accepted core write to the index register
	wire wr0 = coreWrEn && coreReady && coreWrSel == `CRF_SEL_INDEX;
	wire take = vecReq && vecValid;
	// full-word bus write committing this cycle, core port idle
	wire busWr = avs_write && !avs_waitrequest && avs_byteenable == 4'hF && !coreWrEn;

	property p_byte;
		wr0 && coreWrSize == CRF_SZ_BYTE |=> indexRegister == 32'($signed($past(coreWrData[7:0])));
	endproperty
	property p_long;
		wr0 && coreWrSize == CRF_SZ_LONG |=> indexRegister == $past(coreWrData);
	endproperty
	property p_mac;
		macWrEn && avs_waitrequest && !(coreWrEn && coreWrSel == `CRF_SEL_MUL_ACC_HIGH)
		|=> mulAccHigh == $past(macHighIn);
	endproperty
	property p_pc;
		take && !vecAddr[2] |=> programCounter == $past(vecData) && !coreReady;
	endproperty
	property p_sp;
		take && vecAddr[2] |=> stackPointer == $past(vecData) && coreReady && !vecReq;
	endproperty
	property p_rst;
		$rose(rst_n) |-> processorState == `CRF_SR_RESET && interruptMaskBits == 4'hF
		&& vectorBase == `CRF_VBR_RESET;
	endproperty
	property p_rd;
		rdSelA == `CRF_SEL_VBR |=> rdDataA == vectorBase;
	endproperty
	property p_ans;
		(avs_read || avs_write) && avs_waitrequest && coreReady |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	property p_mul_acc_low;
		macWrEn && avs_waitrequest && !(coreWrEn && coreWrSel == `CRF_SEL_MUL_ACC_LOW)
		|=> mulAccLow == $past(macLowIn);
	endproperty
	property p_rdb;
		rdSelB == `CRF_SEL_SR |=> rdDataB == processorState;
	endproperty
	property p_pr;
		busWr && avs_address == `CRF_OFF_PR |=> returnAddress == $past(avs_writedata);
	endproperty
	property p_gbr;
		busWr && avs_address == `CRF_OFF_GBR |=> globalBase == $past(avs_writedata);
	endproperty
	property p_boot;
		!coreReady |=> vectorBase == 32'h0000_0000 && avs_waitrequest;
	endproperty

	a_byte: assert property (p_byte) else $error("byte not sign extended");
	a_long: assert property (p_long) else $error("long write lost");
	a_mac: assert property (p_mac) else $error("mac high not loaded");
	a_pc: assert property (p_pc) else $error("pc not fetched");
	a_sp: assert property (p_sp) else $error("stack word not fetched");
	a_rst: assert property (p_rst) else $error("bad reset values");
	a_rd: assert property (p_rd) else $error("stale read port");
	a_ans: assert property (p_ans) else $error("bus answer timing");
	a_boot: assert property (p_boot) else $error("change before boot");
	a_mul_acc_low: assert property (p_mul_acc_low) else $error("mac low not loaded");
	a_rdb: assert property (p_rdb) else $error("stale second read port");
	a_pr: assert property (p_pr) else $error("return register not written");
	a_gbr: assert property (p_gbr) else $error("global base not written");
	c_sp: cover property (take && vecAddr[2]);
	c_byte: cover property (wr0 && coreWrSize == CRF_SZ_BYTE);
	c_ans: cover property (avs_read && !avs_waitrequest);
endmodule : crf_cpu_register_file_props

bind crf_cpu_register_file crf_cpu_register_file_props i_props (.*);

/* File: testbench/crf_vec_model.sv */
`timescale 1ns/1ns

// vector table source, one word per pulse, gap+1 idle cycles between pulses
module crf_vec_model
	import crf_pkg::*;
#(
	parameter crf_word_t PC_WORD = 32'h0000_0000,
	parameter crf_word_t SP_WORD = 32'h0000_0000
) (
	input  wire logic       clk, rst_n, vecReq,
	input  wire crf_word_t  vecAddr,
	input  wire logic [1:0] gap,
	output crf_word_t       vecData,
	output logic            vecValid
);
	logic [1:0] idleLeft;

	// data scrambled whenever not valid
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{vecValid, vecData, idleLeft} <= '0;
		end else if (vecValid) begin
			vecValid <= 1'b0;
			vecData  <= ~vecData;
			idleLeft <= gap;
		end else if (vecReq && idleLeft == 2'h0) begin
			vecValid <= 1'b1;
			vecData  <= vecAddr[2] ? SP_WORD : PC_WORD;
		end else begin
			vecData  <= ~vecData;
			idleLeft <= idleLeft - {1'b0, idleLeft != 2'h0};
		end
	end
endmodule : crf_vec_model

/* File: testbench/crf_cpu_register_file_bench.sv */
`timescale 1ns/1ns
`include "crf_defines.svh"

module crf_cpu_register_file_bench
	import crf_pkg::*;
;
	localparam crf_word_t PC_WORD = 32'h0000_2468;
	localparam crf_word_t SP_WORD = 32'h0000_7FF0;
	logic       clk, rst_n, coreWrEn, macWrEn, avs_read, avs_write, vecValid, vecReq;
	logic       coreReady, avs_waitrequest;
	logic [1:0] gap;
	logic [7:0] avs_address;
	crf_sel_t   coreWrSel, rdSelA, rdSelB;
	crf_size_e  coreWrSize;
	crf_word_t  coreWrData, macHighIn, macLowIn, vecData, vecAddr, avs_writedata, avs_readdata;
	crf_word_t  expq[$];
	int         bad_count, samples_checked;

	crf_cpu_register_file i_dut (.avs_byteenable(4'hF), .rdDataA(), .rdDataB(), .indexRegister(),
		.stackPointer(), .processorState(), .interruptMaskBits(), .globalBase(), .vectorBase(),
		.mulAccHigh(), .mulAccLow(), .returnAddress(), .programCounter(), .*);
	crf_vec_model #(.PC_WORD(PC_WORD), .SP_WORD(SP_WORD)) i_vec (.*);

	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// random read port selectors
	always @(posedge clk) begin
		rdSelA <= 5'($urandom_range(0, 23));
		rdSelB <= 5'($urandom_range(0, 23));
	end

	// readdata against the oldest note
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			samples_checked++;
			if (expq.size() == 0 || avs_readdata !== expq[0]) begin
				bad_count++;
				$display("BAD readdata exp %h got %h", expq.size() ? expq[0] : 'x, avs_readdata);
			end
			if (expq.size()) void'(expq.pop_front());
		end
	end

	task automatic bus(input logic w, input logic [7:0] a, input crf_word_t d);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic rd(input logic [7:0] a, input crf_word_t e);
		expq.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	task automatic cw(input crf_sel_t s, input crf_size_e z, input crf_word_t d);
		{coreWrEn, coreWrSel, coreWrSize, coreWrData} <= {1'b1, s, z, d};
		@(posedge clk);
		coreWrEn <= 1'b0;
	endtask : cw

	task automatic boot(input logic [1:0] g);
		rst_n <= 1'b0;
		gap   <= g;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
	endtask : boot

	task automatic report_and_stop;
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	// hang guard, far beyond the few hundred cycles of the run
	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end

	// main sequence
	initial begin
		crf_word_t d;
		int s;
		crf_size_e z;
		{rst_n, coreWrEn, macWrEn, avs_read, avs_write, gap, avs_address} = '0;
		{coreWrSel, coreWrData, macHighIn, macLowIn, avs_writedata, rdSelA, rdSelB} = '0;
		coreWrSize = CRF_SZ_LONG;
		void'($urandom(20744));
		boot(2'h0);
		rd(`CRF_OFF_VBR, 32'h0000_0000);
		rd(`CRF_OFF_PC, PC_WORD);
		rd(8'h3C, SP_WORD);
		rd(`CRF_OFF_SR, `CRF_SR_RESET);
		// byte write into the index register
		cw(`CRF_SEL_INDEX, CRF_SZ_BYTE, 32'h1234_5680);
		rd(`CRF_OFF_GPR0, 32'hFFFF_FF80);
		// core writes of every size, then read back
		repeat (12) begin
			s = $urandom_range(0, 15);
			z = crf_size_e'($urandom_range(0, 2));
			d = $urandom;
			cw(5'(s), z, d);
			rd(8'(s * 4), z == CRF_SZ_BYTE ? 32'($signed(d[7:0])) :
				z == CRF_SZ_WORD ? 32'($signed(d[15:0])) : d);
		end
		// control and system registers over the bus
		for (s = 17; s <= 22; s++) begin
			d = $urandom;
			bus(1'b1, 8'(s * 4), d);
			rd(8'(s * 4), d);
		end
		bus(1'b1, `CRF_OFF_SR, 32'hFFFF_FFFF);
		rd(`CRF_OFF_SR, `CRF_SR_WRITABLE);
		bus(1'b1, `CRF_OFF_STAT, 32'h0000_0000);
		rd(`CRF_OFF_STAT, 32'h0000_0001);
		rd(8'h60, 32'h0000_0000);
		// multiply results
		{macHighIn, macLowIn, macWrEn} <= {32'($urandom), 32'($urandom), 1'b1};
		@(posedge clk);
		macWrEn <= 1'b0;
		rd(`CRF_OFF_MUL_ACC_HIGH, macHighIn);
		rd(`CRF_OFF_MUL_ACC_LOW, macLowIn);
		// second reset with a slow vector source
		bus(1'b1, `CRF_OFF_VBR, 32'h0000_0100);
		boot(2'h2);
		rd(`CRF_OFF_VBR, 32'h0000_0000);
		rd(`CRF_OFF_PC, PC_WORD);
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule : crf_cpu_register_file_bench
